// ### bench/hms_axis_model.sv
`timescale 1ns/10ps
module hms_axis_model (
   input  wire clk_i,
   input  wire run_i,
   input  wire fast_i,
   input  wire fwd_i,
   output wire home_switch_o,
   output wire neg_limit_o,
   output wire pos_limit_o,
   output wire index_o,
   output wire torque_limit_o,
   output wire speed_zero_o
);
   // axis travel in position units; the bench places it before each run
   integer pos = 0;
   wire    at_stop = run_i && (fwd_i ? pos >= 500 : pos <= -10);
   assign home_switch_o  = pos >= 200 && pos <= 260;
   assign neg_limit_o    = pos <= 20;
   assign pos_limit_o    = pos >= 480;
   assign index_o        = ((pos % 64) + 64) % 64 == 0;
   assign torque_limit_o = at_stop;
   assign speed_zero_o   = !run_i || at_stop;
   always @(posedge clk_i) begin
      if (run_i && !at_stop) pos <= pos + (fwd_i ? 1 : -1) * (fast_i ? 2 : 1);
   end
endmodule // hms_axis_model

// ### bench/hms_seq_props.sv
`timescale 1ns/10ps
module hms_seq_props (
   input wire        clk_i,
   input wire        rst_i,
   input wire        ce_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [7:0]  wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        home_switch_i,
   input wire        neg_limit_i,
   input wire        pos_limit_i,
   input wire        index_i,
   input wire        torque_limit_i,
   input wire        speed_zero_i,
   input wire        run_o,
   input wire        fast_o,
   input wire        fwd_o,
   input wire        busy_o,
   input wire        done_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire [4:0] pins = {home_switch_i, neg_limit_i, pos_limit_i, index_i, torque_limit_i};
   reg  [4:0] pins_q;
   reg  [3:0] quiet_cnt;
   // cycles since a switch, limit, index or torque change; a heading change needs a recent cause
   always @(posedge clk_i) begin
      pins_q <= pins;
      if (rst_i || pins != pins_q) quiet_cnt <= 4'h0;
      else if (quiet_cnt != 4'hF) quiet_cnt <= quiet_cnt + 4'h1;
   end
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   ack_on_time_a: assert property (s_req |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   unmapped_zero_a: assert property (s_req ##0 (!wb_we_i && wb_adr_i >= 8'h20) |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   run_in_seq_a: assert property (run_o |-> busy_o)
      else $error("motion outside a sequence");
   done_stops_a: assert property ($rose(done_o) |-> ##[0:1] (!run_o && !busy_o))
      else $error("completion while moving");
   start_clears_a: assert property ($rose(busy_o) |-> ##[0:1] !done_o)
      else $error("done kept over a new start");
   heading_cause_a: assert property (run_o && $past(run_o) && $changed({fast_o, fwd_o}) |-> quiet_cnt <= 4'hE)
      else $error("command change without input cause");
endmodule // hms_seq_props

bind hms_homing_sequencer hms_seq_props u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .home_switch_i(home_switch_i), .neg_limit_i(neg_limit_i), .pos_limit_i(pos_limit_i),
   .index_i(index_i), .torque_limit_i(torque_limit_i), .speed_zero_i(speed_zero_i),
   .run_o(run_o), .fast_o(fast_o), .fwd_o(fwd_o), .busy_o(busy_o), .done_o(done_o));

// ### bench/tb_homing_sequencer.sv
`timescale 1ns/10ps
`include "hms_map.vh"
module tb_homing_sequencer;
   localparam [2:0] rlo = `HMS_CMD_RLO, flo = `HMS_CMD_FLO, rhi = `HMS_CMD_RHI;
   localparam [2:0] fhi = `HMS_CMD_FHI;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         cyc = 1'b0, stb = 1'b0, we = 1'b0;
   reg  [7:0]  adr = 8'h00;
   reg  [31:0] wdat = 32'h0, rdat;
   reg  [14:0] seq = 15'h0;
   reg  [2:0]  cmd_q = 3'h0;
   integer     errors = 0, total_checks = 0, i;
   wire [31:0] dat_o;
   wire        ack, run, fast, fwd, busy, done, hs, nl, pl, ix, tq, sz;
   always #2.5 clk_i = ~clk_i;
   hms_homing_sequencer DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .home_switch_i(hs), .neg_limit_i(nl),
      .pos_limit_i(pl), .index_i(ix), .torque_limit_i(tq), .speed_zero_i(sz),
      .run_o(run), .fast_o(fast), .fwd_o(fwd), .busy_o(busy), .done_o(done));
   hms_axis_model axis (.clk_i(clk_i), .run_i(run), .fast_i(fast), .fwd_i(fwd),
      .home_switch_o(hs), .neg_limit_o(nl), .pos_limit_o(pl), .index_o(ix),
      .torque_limit_o(tq), .speed_zero_o(sz));
   // log each new motion command so a whole run is compared in one go
   always @(posedge clk_i) begin
      cmd_q <= {run, fast, fwd};
      if (run === 1'b1 && {run, fast, fwd} !== cmd_q) seq <= {seq[11:0], run, fast, fwd};
   end
   task wrap_up;
      begin
         $display("checks %0d errors %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input [8*10:1] nm, input [31:0] e, input [31:0] g);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task bus(input [7:0] a, input [31:0] d, input w);
      integer n;
      begin
         @(posedge clk_i);
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         wdat <= d;
         n = 0;
         @(posedge clk_i);
         while (ack !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n = n + 1;
         end
         if (n == 40) chk("ack", 32'h1, 32'h0);
         rdat = dat_o;
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask
   task start(input [7:0] m);
      begin
         bus(`HMS_A_METHOD, {24'h0, m}, 1'b1);
         bus(`HMS_A_CTRL, {16'h0, `HMS_CW_READY}, 1'b1);
         bus(`HMS_A_CTRL, {16'h0, `HMS_CW_START}, 1'b1);
         repeat (3) @(posedge clk_i);
      end
   endtask
   task home(input [7:0] m, input integer p, input [14:0] e);
      integer n;
      begin
         axis.pos = p;
         repeat (8) @(posedge clk_i);
         seq = 15'h0;
         start(m);
         n = 0;
         while (done !== 1'b1 && n < 4000) begin
            @(posedge clk_i);
            n = n + 1;
         end
         chk("motion", {17'h0, e}, {17'h0, seq});
         chk("state", 32'h4, {29'h0, done, busy, run});
      end
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(`HMS_A_QUAL, 32'h0, 1'b0);
      chk("qual reset", 32'h64, rdat);
      bus(8'h40, 32'hFFFFFFFF, 1'b1);
      bus(8'h40, 32'h0, 1'b0);
      chk("unmapped", 32'h0, rdat);
      bus(`HMS_A_CMD, 32'h7, 1'b1);
      bus(`HMS_A_CMD, 32'h0, 1'b0);
      chk("cmd ro", 32'h0, rdat);
      bus(`HMS_A_METHOD, {24'h0, `HMS_M35}, 1'b1);
      bus(`HMS_A_CTRL, {16'h0, `HMS_CW_START}, 1'b1);
      repeat (4) @(posedge clk_i);
      chk("no start", 32'h0, {31'h0, done});
      bus(`HMS_A_QUAL, 32'h3, 1'b1);
      bus(`HMS_A_OFFSET, 32'h20, 1'b1);
      for (i = 0; i < 2; i = i + 1) begin
         bus(`HMS_A_TYPE, i, 1'b1);
         bus(`HMS_A_POS, 32'h1000, 1'b1);
         home(`HMS_M35, 400, 15'h0);
         bus(`HMS_A_POS, 32'h0, 1'b0);
         chk("position", i ? 32'h1020 : 32'h20, rdat);
      end
      home(`HMS_M27, 400, {rhi, flo});
      home(`HMS_M27, 100, {rhi, flo, rlo, flo});
      home(`HMS_M27, 230, {flo});
      home(`HMS_M28, 400, {rhi, flo, rlo});
      home(`HMS_M28, 100, {rhi, fhi, flo, rlo});
      home(`HMS_M28, 230, {flo, rlo});
      home(`HMS_M29, 400, {rhi, rlo, flo});
      home(`HMS_M29, 100, {rhi, fhi, rlo, flo});
      home(`HMS_M29, 230, {rlo, flo});
      home(`HMS_M30, 400, {rhi, rlo, flo, rlo});
      home(`HMS_M30, 100, {rhi, fhi, rlo});
      home(`HMS_M30, 230, {rlo});
      home(`HMS_M33, 400, {rlo});
      home(`HMS_M34, 100, {flo});
      home(`HMS_MN1, 100, {rhi, flo});
      home(`HMS_MN2, 400, {fhi, rlo});
      for (i = 0; i < 2; i = i + 1) begin
         start(i ? `HMS_M32 : `HMS_M31);
         bus(`HMS_A_STATUS, 32'h0, 1'b0);
         chk("undefined", 32'h4, rdat);
         chk("no motion", 32'h0, {31'h0, run});
      end
      wrap_up;
   end
   initial begin
      #400000;
      chk("watchdog", 32'h1, 32'h0);
      wrap_up;
   end
endmodule // tb_homing_sequencer

// ### hw/hms_homing_sequencer.v
`timescale 1ns/10ps
// Function
// - m27 free start: rev fast, fwd slow, stop fall
// - m27 limit: fwd, rise, fall rev, rise fwd, fall
// - m27 switch on: fwd slow, stop at fall
// - m28 free: rev fast, fwd, rev, stop rise
// - m28 limit: fwd fast, rise slow, fall rev, stop rise
// - m28 switch on: fwd, fall rev, stop rise
// - m29 free: rev fast, rev slow, fall fwd, rise
// - m29 limit: fwd fast, rise rev, fall fwd, rise
// - m29 switch on: rev, fall fwd, stop rise
// - m30 free: rev, fall fwd, rise rev, stop fall
// - m30 limit: fwd fast, rise rev, stop fall
// - m30 switch on: rev slow, stop at fall
// - methods 31 and 32 are undefined, error
// - m33 reverse slow, stop at first index
// - m34 forward slow, stop at first index
// - m35 starts on control word 0F to 1F
// - absolute type loads position with offset
// - relative type adds offset to position
// - m-1 reverse to hard stop, fwd to index
// - m-2 forward to hard stop, rev to index
`include "hms_map.vh"

module hms_homing_sequencer (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        home_switch_i,
   input  wire        neg_limit_i,
   input  wire        pos_limit_i,
   input  wire        index_i,
   input  wire        torque_limit_i,
   input  wire        speed_zero_i,
   output reg         run_o,
   output reg         fast_o,
   output reg         fwd_o,
   output reg         busy_o,
   output reg         done_o
);

   // phase states: S0 fast search, S1 forward after a limit, S2 on the switch
   // after a search edge, S3 started on the switch, S4 waiting for the last
   // rising edge; HARD runs into the end stop, IDX waits for the index pulse;
   // the command flop, not the state, says which way and how fast we move
   localparam ST_IDLE = 3'h0;
   localparam ST_S0   = 3'h1;
   localparam ST_S1   = 3'h2;
   localparam ST_S2   = 3'h3;
   localparam ST_S3   = 3'h4;
   localparam ST_S4   = 3'h5;
   localparam ST_HARD = 3'h6;
   localparam ST_IDX  = 3'h7;

   // pin synchronisers: first stage feeds only the second
   wire [5:0] pin_vec  = {speed_zero_i, torque_limit_i, index_i,
                          pos_limit_i, neg_limit_i, home_switch_i};
   reg  [5:0] sync1_reg;
   reg  [5:0] sync2_reg;
   reg        hsw_d_reg;
   reg        idx_d_reg;
   wire       hsw      = sync2_reg[0];
   wire       nlim     = sync2_reg[1];
   wire       plim     = sync2_reg[2];
   wire       idx      = sync2_reg[3];
   wire       tlim     = sync2_reg[4];
   wire       szero    = sync2_reg[5];
   // edge registers reset low, the idle level of both pins; a pin that is
   // high after reset can only fake an edge in a state that ignores it
   wire       hsw_rise = hsw & ~hsw_d_reg;
   wire       hsw_fall = ~hsw & hsw_d_reg;
   wire       idx_rise = idx & ~idx_d_reg;

   reg [15:0] cw_reg;
   reg [15:0] cw_prev_reg;
   reg [7:0]  method_reg;
   reg        type_reg;
   reg [31:0] offset_reg;
   reg [31:0] pos_reg;
   reg [15:0] qual_reg;
   reg [15:0] hold_cnt_reg;
   reg [2:0]  state_reg;
   reg [2:0]  state_next;
   reg [2:0]  cmd_reg;
   reg [2:0]  cmd_next;
   reg        lim_reg;
   reg        lim_next;
   reg        err_reg;
   reg        fin_next;
   reg        err_next;

   wire       wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // a write lands on the edge at which the master sees ack, never earlier
   wire       wb_wr   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   // the ready word must have stood for a cycle before the start word
   wire       start   = (cw_prev_reg == `HMS_CW_READY) & (cw_reg == `HMS_CW_START);
   // the stall must still stand at the qualifying edge, not only have stood
   wire       hard_ok = (hold_cnt_reg >= qual_reg) & tlim & szero;
   // either limit counts; only the fast reverse search can meet one
   wire       lim_hit = (cmd_reg == `HMS_CMD_RHI) & (nlim | plim);

   // byte-lane merge shared by the ctrl, offset, pos and qual registers; method and type take lane 0 only
   function [31:0] lane_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  sel;
      integer k;
      begin
         lane_merge = old_v;
         for (k = 0; k < 4; k = k + 1) begin
            if (sel[k]) begin
               lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
            end
         end
      end
   endfunction

   // 16-bit registers keep only the low half of the merged word
   wire [31:0] cw_merge   = lane_merge({16'h0000, cw_reg}, wb_dat_i, wb_sel_i);
   wire [31:0] qual_merge = lane_merge({16'h0000, qual_reg}, wb_dat_i, wb_sel_i);

   // status word laid out from the bit map so software and logic agree
   reg  [31:0] status_word;
   always @* begin
      status_word               = 32'h0000_0000;
      status_word[`HMS_ST_BUSY] = busy_o;
      status_word[`HMS_ST_DONE] = done_o;
      status_word[`HMS_ST_ERR]  = err_reg;
   end

   // step table: returns {stop, cmd} for each phase, start flag and limit path
   always @* begin
      state_next = state_reg;
      cmd_next   = cmd_reg;
      lim_next   = lim_reg;
      fin_next   = 1'b0;
      err_next   = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (start) begin
               lim_next = 1'b0;
               // the switch level at start picks the on-switch or the search branch
               case (method_reg)
                  `HMS_M27, `HMS_M28: begin
                     state_next = hsw ? ST_S3 : ST_S0;
                     cmd_next   = hsw ? `HMS_CMD_FLO : `HMS_CMD_RHI;
                  end
                  `HMS_M29, `HMS_M30: begin
                     state_next = hsw ? ST_S3 : ST_S0;
                     cmd_next   = hsw ? `HMS_CMD_RLO : `HMS_CMD_RHI;
                  end
                  `HMS_M33: begin
                     state_next = ST_IDX;
                     cmd_next   = `HMS_CMD_RLO;
                  end
                  `HMS_M34: begin
                     state_next = ST_IDX;
                     cmd_next   = `HMS_CMD_FLO;
                  end
                  `HMS_M35: begin
                     fin_next = 1'b1;
                  end
                  `HMS_MN1: begin
                     state_next = ST_HARD;
                     cmd_next   = `HMS_CMD_RHI;
                  end
                  `HMS_MN2: begin
                     state_next = ST_HARD;
                     cmd_next   = `HMS_CMD_FHI;
                  end
                  default: begin
                     // 31, 32 and any other code: no motion, flagged
                     err_next = 1'b1;
                  end
               endcase
            end
         end
         ST_S0: begin
            // fast reverse search; a limit turns the axis round
            // limits are watched only in this first fast search
            if (lim_hit) begin
               lim_next   = 1'b1;
               cmd_next   = (method_reg == `HMS_M27) ? `HMS_CMD_FLO : `HMS_CMD_FHI;
               state_next = ST_S1;
            end else if (hsw_rise) begin
               case (method_reg)
                  `HMS_M27, `HMS_M28: cmd_next = `HMS_CMD_FLO;
                  default:            cmd_next = `HMS_CMD_RLO;
               endcase
               state_next = ST_S2;
            end
         end
         ST_S1: begin
            // forward after limit, waiting for the switch rising edge
            if (hsw_rise) begin
               case (method_reg)
                  `HMS_M27: cmd_next = `HMS_CMD_FLO;
                  `HMS_M28: cmd_next = `HMS_CMD_FLO;
                  default:  cmd_next = `HMS_CMD_RLO;
               endcase
               state_next = ST_S2;
            end
         end
         ST_S2: begin
            // on the switch, waiting for its falling edge
            if (hsw_fall) begin
               if (method_reg == `HMS_M27 && !lim_reg) begin
                  cmd_next   = `HMS_CMD_STOP;
                  fin_next   = 1'b1;
                  state_next = ST_IDLE;
               end else if (method_reg == `HMS_M30 && lim_reg) begin
                  cmd_next   = `HMS_CMD_STOP;
                  fin_next   = 1'b1;
                  state_next = ST_IDLE;
               end else begin
                  case (method_reg)
                     `HMS_M27, `HMS_M28: cmd_next = `HMS_CMD_RLO;
                     default:            cmd_next = `HMS_CMD_FLO;
                  endcase
                  state_next = ST_S4;
               end
            end
         end
         ST_S3: begin
            // started on the switch, waiting for its falling edge
            if (hsw_fall) begin
               if (method_reg == `HMS_M27 || method_reg == `HMS_M30) begin
                  cmd_next   = `HMS_CMD_STOP;
                  fin_next   = 1'b1;
                  state_next = ST_IDLE;
               end else begin
                  cmd_next   = (method_reg == `HMS_M28) ? `HMS_CMD_RLO : `HMS_CMD_FLO;
                  state_next = ST_S4;
               end
            end
         end
         ST_S4: begin
            // last rising edge: stop, or for 27 and 30 one more pass
            if (hsw_rise) begin
               if (method_reg == `HMS_M27 || method_reg == `HMS_M30) begin
                  cmd_next   = (method_reg == `HMS_M27) ? `HMS_CMD_FLO : `HMS_CMD_RLO;
                  // 30 marks its last pass so the next fall stops it; 27 clears the mark
                  lim_next   = (method_reg == `HMS_M30);
                  state_next = ST_S2;
               end else begin
                  cmd_next   = `HMS_CMD_STOP;
                  fin_next   = 1'b1;
                  state_next = ST_IDLE;
               end
            end
         end
         ST_HARD: begin
            // driving into the end stop until the stall has qualified
            if (hard_ok) begin
               cmd_next   = (method_reg == `HMS_MN1) ? `HMS_CMD_FLO : `HMS_CMD_RLO;
               state_next = ST_IDX;
            end
         end
         ST_IDX: begin
            // slow run to the first index rising edge
            if (idx_rise) begin
               cmd_next   = `HMS_CMD_STOP;
               fin_next   = 1'b1;
               state_next = ST_IDLE;
            end
         end
         default: begin
            // unused code: park the axis rather than run on
            state_next = ST_IDLE;
            cmd_next   = `HMS_CMD_STOP;
         end
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         sync1_reg    <= 6'h00;
         sync2_reg    <= 6'h00;
         hsw_d_reg    <= 1'b0;
         idx_d_reg    <= 1'b0;
         cw_reg       <= 16'h0000;
         cw_prev_reg  <= 16'h0000;
         method_reg   <= 8'h00;
         type_reg     <= 1'b0;
         offset_reg   <= 32'h0000_0000;
         pos_reg      <= 32'h0000_0000;
         qual_reg     <= `HMS_QUAL_RST;
         hold_cnt_reg <= 16'h0000;
         state_reg    <= ST_IDLE;
         cmd_reg      <= `HMS_CMD_STOP;
         lim_reg      <= 1'b0;
         err_reg      <= 1'b0;
         done_o       <= 1'b0;
         wb_ack_o     <= 1'b0;
         wb_dat_o     <= 32'h0000_0000;
      end else if (ce_i) begin
         // with ce low every register, the bus ack included, holds its value
         sync1_reg   <= pin_vec;
         sync2_reg   <= sync1_reg;
         hsw_d_reg   <= hsw;
         idx_d_reg   <= idx;
         cw_prev_reg <= cw_reg;
         state_reg   <= state_next;
         cmd_reg     <= cmd_next;
         lim_reg     <= lim_next;
         // counter restarts whenever the stall condition breaks
         // and saturates, so a long stall never wraps below the threshold
         if (state_reg == ST_HARD && tlim && szero) begin
            if (hold_cnt_reg != 16'hFFFF) begin
               hold_cnt_reg <= hold_cnt_reg + 16'h0001;
            end
         end else begin
            hold_cnt_reg <= 16'h0000;
         end
         wb_ack_o <= wb_req;
         if (wb_wr) begin
            case (wb_adr_i)
               `HMS_A_CTRL:   cw_reg     <= cw_merge[15:0];
               `HMS_A_METHOD: method_reg <= wb_sel_i[0] ? wb_dat_i[7:0] : method_reg;
               `HMS_A_TYPE:   type_reg   <= wb_sel_i[0] ? wb_dat_i[0] : type_reg;
               `HMS_A_OFFSET: offset_reg <= lane_merge(offset_reg, wb_dat_i, wb_sel_i);
               `HMS_A_QUAL:   qual_reg   <= qual_merge[15:0];
               default: ;
            endcase
         end
         // homing completion owns the position over a same-cycle write
         if (fin_next) begin
            pos_reg <= type_reg ? pos_reg + offset_reg : offset_reg;
         end else if (wb_wr && wb_adr_i == `HMS_A_POS) begin
            pos_reg <= lane_merge(pos_reg, wb_dat_i, wb_sel_i);
         end
         // set wins over a start that clears the flags
         if (fin_next) begin
            done_o <= 1'b1;
         end else if (start) begin
            done_o <= 1'b0;
         end
         if (err_next) begin
            err_reg <= 1'b1;
         end else if (start) begin
            err_reg <= 1'b0;
         end
         // read data is loaded every cycle, so it already stands when ack does
         case (wb_adr_i)
            `HMS_A_CTRL:   wb_dat_o <= {16'h0000, cw_reg};
            `HMS_A_METHOD: wb_dat_o <= {24'h000000, method_reg};
            `HMS_A_TYPE:   wb_dat_o <= {31'h00000000, type_reg};
            `HMS_A_OFFSET: wb_dat_o <= offset_reg;
            `HMS_A_POS:    wb_dat_o <= pos_reg;
            `HMS_A_STATUS: wb_dat_o <= status_word;
            `HMS_A_QUAL:   wb_dat_o <= {16'h0000, qual_reg};
            `HMS_A_CMD:    wb_dat_o <= {29'h00000000, cmd_reg};
            default:       wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // motion outputs decode straight from the command flop
   always @* begin
      run_o  = cmd_reg[2];
      fast_o = cmd_reg[1];
      fwd_o  = cmd_reg[0];
      busy_o = (state_reg != ST_IDLE);
   end

endmodule // hms_homing_sequencer

// ### inc/hms_map.vh
`ifndef HMS_MAP_VH
`define HMS_MAP_VH

// register byte addresses (word aligned)
`define HMS_A_CTRL      8'h00
`define HMS_A_METHOD    8'h04
`define HMS_A_TYPE      8'h08
`define HMS_A_OFFSET    8'h0C
`define HMS_A_POS       8'h10
`define HMS_A_STATUS    8'h14
`define HMS_A_QUAL      8'h18
`define HMS_A_CMD       8'h1C

// control word values that start homing
`define HMS_CW_READY    16'h000F
`define HMS_CW_START    16'h001F

// method codes, 8-bit two's complement
`define HMS_M27         8'h1B
`define HMS_M28         8'h1C
`define HMS_M29         8'h1D
`define HMS_M30         8'h1E
`define HMS_M31         8'h1F
`define HMS_M32         8'h20
`define HMS_M33         8'h21
`define HMS_M34         8'h22
`define HMS_M35         8'h23
`define HMS_MN1         8'hFF
`define HMS_MN2         8'hFE

// command encoding: {run, fast, fwd}
`define HMS_CMD_STOP    3'h0
`define HMS_CMD_RLO     3'h4
`define HMS_CMD_FLO     3'h5
`define HMS_CMD_RHI     3'h6
`define HMS_CMD_FHI     3'h7

// status bits
`define HMS_ST_BUSY     0
`define HMS_ST_DONE     1
`define HMS_ST_ERR      2

`define HMS_QUAL_RST    16'h0064

`endif
